// File: hdl/timer16_wave_mode_control.sv
// 16-bit timer with wave mode control, three compare pins, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"
module timer16_wave_mode_control (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] portData,
	input wire logic [2:0] portDirOut,
	output logic [2:0] pinOut,
	output logic [2:0] pinOeN,
	output logic overflowFlag
);
	localparam logic [7:0] CMP_OFS [3] = '{`OFS_CMP_A, `OFS_CMP_B, `OFS_CMP_C};
	localparam int ACT_LSB [3] = '{`ACT_A_LSB, `ACT_B_LSB, `ACT_C_LSB};

	function automatic logic [15:0] mergeHalf(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [15:0] res;
		res = old;
		if (strb[0])
			res[7:0] = data[7:0];
		if (strb[1])
			res[15:8] = data[15:8];
		return res;
	endfunction : mergeHalf

	// control and data registers
	logic [7:0] outputModeCtrl_r;
	logic [1:0] waveHigh_r;
	logic [15:0] cmpBuf_r [3];
	logic [15:0] cmpAct_r [3];
	logic [15:0] capture_r;
	logic [15:0] count_r;
	logic countUp_r;
	logic overflow_r;
	logic [2:0] pinOut_r;
	logic [2:0] pinOeN_r;

	// bus state
	logic awHeld_r;
	logic wHeld_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// write channel: address and data are accepted in either order
	assign s_axi_awready = ~awHeld_r & ~bvalid_r;
	assign s_axi_wready = ~wHeld_r & ~bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	wire awFire = s_axi_awvalid & s_axi_awready;
	wire wFire = s_axi_wvalid & s_axi_wready;
	wire wrDo = awHeld_r & wHeld_r;
	wire [7:0] wrAddr = {awAddr_r[7:2], 2'b00};
	wire wrOutCtrl = wrDo & (wrAddr == `OFS_OUT_MODE_CTRL);
	wire wrClkCtrl = wrDo & (wrAddr == `OFS_CLK_MODE_CTRL);
	wire wrCapture = wrDo & (wrAddr == `OFS_CAPTURE);
	wire wrStatus = wrDo & (wrAddr == `OFS_STATUS);
	wire wrCount = wrAddr == `OFS_COUNT;
	wire [2:0] wrCmp;
	wire wrHit = wrOutCtrl | wrClkCtrl | wrCapture | wrStatus | (|wrCmp) |
		(wrDo & wrCount);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
		end else begin
			if (awFire)
				awAddr_r <= s_axi_awaddr;
			if (wFire) begin
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			awHeld_r <= wrDo ? 1'b0 : (awHeld_r | awFire);
			wHeld_r <= wrDo ? 1'b0 : (wHeld_r | wFire);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (wrDo) begin
			bvalid_r <= 1'b1;
			bresp_r <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// mode decode
	wire [3:0] waveModeSelect = {waveHigh_r,
		outputModeCtrl_r[`WAVE_LO_LSB +: 2]};
	wire waveModeTopBit = waveModeSelect[3];
	timer16_pkg::modeClass_t modeClass;
	timer16_pkg::eventPoint_t updatePoint;
	timer16_pkg::eventPoint_t overflowPoint;
	logic [15:0] topValue;

	wave_mode_decode u_decode (
		.waveModeSelect(waveModeSelect),
		.captureValue(capture_r),
		.compareValueA(cmpAct_r[0]),
		.modeClass(modeClass),
		.topValue(topValue),
		.updatePoint(updatePoint),
		.overflowPoint(overflowPoint)
	);

	// counter
	wire atTop = count_r == topValue;
	wire atBottom = count_r == `BOTTOM_VAL;
	wire pastTop = count_r >= topValue;
	wire topIsZero = topValue == `BOTTOM_VAL;
	wire isDual = modeClass == timer16_pkg::CLS_DUAL;
	wire isStop = modeClass == timer16_pkg::CLS_STOP;
	wire [15:0] countInc = count_r + 16'h0001;
	wire [15:0] countDec = count_r - 16'h0001;
	// fast modes wrap on overshoot so a lowered TOP cannot run away to MAX
	wire [15:0] singleNxt = (modeClass == timer16_pkg::CLS_NONPWM) ?
		(atTop ? `BOTTOM_VAL : countInc) :
		(pastTop ? `BOTTOM_VAL : countInc);
	wire turnDown = countUp_r & pastTop;
	wire turnUp = ~countUp_r & atBottom;
	wire [15:0] dualNxt = topIsZero ? `BOTTOM_VAL :
		countUp_r ? (turnDown ? countDec : countInc) :
		(turnUp ? countInc : countDec);
	wire countUpNxt = isDual ? (countUp_r ? ~turnDown : turnUp) : 1'b1;
	wire [15:0] countNxt = isStop ? count_r : isDual ? dualNxt : singleNxt;

	// bottom event in dual slope is the turn at zero, not the start-up zero
	wire bottomEvent = isDual ? atBottom & ~countUp_r : atBottom;
	wire overflowEvent =
		((overflowPoint == timer16_pkg::PT_MAX) & (count_r == `TOP_MAX)) |
		((overflowPoint == timer16_pkg::PT_TOP) & atTop) |
		((overflowPoint == timer16_pkg::PT_BOTTOM) & bottomEvent);
	wire updateEvent = ~isStop & (
		(updatePoint == timer16_pkg::PT_IMMED) |
		((updatePoint == timer16_pkg::PT_TOP) & atTop) |
		((updatePoint == timer16_pkg::PT_BOTTOM) & atBottom));

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			count_r <= `BOTTOM_VAL;
			countUp_r <= 1'b1;
		end else begin
			count_r <= countNxt;
			countUp_r <= countUpNxt;
		end
	end

	// flag set by hardware wins over a same-cycle clear
	wire ovfClear = wrStatus & wStrb_r[0] & wData_r[`OVF_BIT];
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			overflow_r <= 1'b0;
		else if (overflowEvent)
			overflow_r <= 1'b1;
		else if (ovfClear)
			overflow_r <= 1'b0;
	end
	assign overflowFlag = overflow_r;

	// control registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			outputModeCtrl_r <= `RST_CTRL;
			waveHigh_r <= 2'b00;
			capture_r <= `RST_WORD;
		end else begin
			if (wrOutCtrl & wStrb_r[0])
				outputModeCtrl_r <= wData_r[7:0];
			if (wrClkCtrl & wStrb_r[0])
				waveHigh_r <= wData_r[`WAVE_HI_LSB +: 2];
			if (wrCapture)
				capture_r <= mergeHalf(capture_r, wData_r, wStrb_r);
		end
	end

	// per-channel compare buffers, active values and pin muxing
	logic [2:0] chanLevel;
	logic [2:0] chanConnected;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_chan
			assign wrCmp[gi] = wrDo & (wrAddr == CMP_OFS[gi]);
			wire [1:0] action = outputModeCtrl_r[ACT_LSB[gi] +: 2];

			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					cmpBuf_r[gi] <= `RST_WORD;
					cmpAct_r[gi] <= `RST_WORD;
				end else begin
					if (wrCmp[gi])
						cmpBuf_r[gi] <= mergeHalf(cmpBuf_r[gi], wData_r, wStrb_r);
					if (updateEvent)
						cmpAct_r[gi] <= cmpBuf_r[gi];
				end
			end

			compare_channel u_chan (
				.clk_sys(clk_sys),
				.rstn(rstn),
				.action(action),
				.modeClass(modeClass),
				.waveModeTopBit(waveModeTopBit),
				.chanIsA(gi == 0),
				.match(count_r == cmpAct_r[gi]),
				.atTop(atTop),
				.countUp(countUp_r),
				.compareIsTop(cmpAct_r[gi] == topValue),
				.outLevel(chanLevel[gi]),
				.connected(chanConnected[gi])
			);

			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					pinOut_r[gi] <= 1'b0;
					pinOeN_r[gi] <= 1'b1;
				end else begin
					pinOut_r[gi] <= chanConnected[gi] ? chanLevel[gi] :
						portData[gi];
					pinOeN_r[gi] <= ~portDirOut[gi];
				end
			end
		end
	endgenerate
	assign pinOut = pinOut_r;
	assign pinOeN = pinOeN_r;

	// read channel: one read at a time, answer the cycle after acceptance
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	wire arFire = s_axi_arvalid & s_axi_arready;
	wire [7:0] rdAddr = {s_axi_araddr[7:2], 2'b00};
	wire rdOutCtrl = rdAddr == `OFS_OUT_MODE_CTRL;
	wire rdClkCtrl = rdAddr == `OFS_CLK_MODE_CTRL;
	wire rdCmpA = rdAddr == `OFS_CMP_A;
	wire rdCmpB = rdAddr == `OFS_CMP_B;
	wire rdCmpC = rdAddr == `OFS_CMP_C;
	wire rdCapture = rdAddr == `OFS_CAPTURE;
	wire rdCount = rdAddr == `OFS_COUNT;
	wire rdStatus = rdAddr == `OFS_STATUS;
	wire rdHit = rdOutCtrl | rdClkCtrl | rdCmpA | rdCmpB | rdCmpC |
		rdCapture | rdCount | rdStatus;
	wire [31:0] rdWord =
		rdOutCtrl ? {24'h000000, outputModeCtrl_r} :
		rdClkCtrl ? {27'h0000000, waveHigh_r, 3'b000} :
		rdCmpA ? {16'h0000, cmpBuf_r[0]} :
		rdCmpB ? {16'h0000, cmpBuf_r[1]} :
		rdCmpC ? {16'h0000, cmpBuf_r[2]} :
		rdCapture ? {16'h0000, capture_r} :
		rdCount ? {16'h0000, count_r} :
		rdStatus ? {31'h00000000, overflow_r} : 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else if (arFire) begin
			rvalid_r <= 1'b1;
			rdata_r <= rdWord;
			rresp_r <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule : timer16_wave_mode_control
`default_nettype wire

// File: hdl/timer16_cfg.svh
// register offsets, field positions, reset values and fixed TOP counts
//Behaviour
// - control register holds 2-bit output actions: A at 7:6, B 5:4, C 3:2
// - action 1x hands the pin over to the compare output; 01 only where it toggles
// - the pin is driven only when its direction bit selects output
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on compare match
// - fast PWM: 10 clears on match and sets at TOP, 11 the reverse
// - PWM code 01: off if mode top bit is 0, else toggle A only
// - fast PWM with compare equal TOP and high bit set: act only at TOP
// - dual slope: 10 clears on up match and sets on down match, 11 reverse
// - 4-bit mode from control bits 1:0 plus two bits elsewhere; 13 reserved
// - mode 0 counts to 0xFFFF, compare loads at once, overflow at MAX
// - mode 4 tops at compare A, mode 12 at capture; immediate; flag at MAX
// - modes 1-3 dual slope with tops 0xFF/0x1FF/0x3FF, load TOP, flag BOTTOM
// - fast modes 5-7 fixed tops, 14 capture, 15 compare A; load and flag TOP
// - modes 8/9 top from capture/compare A; load and flag at BOTTOM
// - modes 10/11 top from capture/compare A; load TOP, flag at BOTTOM
// - dual slope counts zero up to TOP and back down, over and over
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

`define OFS_OUT_MODE_CTRL 8'h00
`define OFS_CLK_MODE_CTRL 8'h04
`define OFS_CMP_A 8'h08
`define OFS_CMP_B 8'h0C
`define OFS_CMP_C 8'h10
`define OFS_CAPTURE 8'h14
`define OFS_COUNT 8'h18
`define OFS_STATUS 8'h1C

`define ACT_A_LSB 6
`define ACT_B_LSB 4
`define ACT_C_LSB 2
`define WAVE_LO_LSB 0
`define WAVE_HI_LSB 3
`define OVF_BIT 0

`define RST_CTRL 8'h00
`define RST_WORD 16'h0000

`define TOP_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define BOTTOM_VAL 16'h0000

`define MODE_NORMAL 4'h0
`define MODE_CTC_CMP 4'h4
`define MODE_CTC_CAP 4'hC
`define MODE_RSVD 4'hD

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hdl/timer16_pkg.sv
// types shared by the wave mode timer files
package timer16_pkg;
	typedef enum logic [1:0] {
		CLS_NONPWM = 2'b00,
		CLS_FAST = 2'b01,
		CLS_DUAL = 2'b10,
		CLS_STOP = 2'b11
	} modeClass_t;
	typedef enum logic [1:0] {
		PT_IMMED = 2'b00,
		PT_TOP = 2'b01,
		PT_BOTTOM = 2'b10,
		PT_MAX = 2'b11
	} eventPoint_t;
endpackage : timer16_pkg

// File: hdl/wave_mode_decode.sv
// decodes the 4-bit wave mode into class, TOP source and event points
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"
module wave_mode_decode (
	input wire logic [3:0] waveModeSelect,
	input wire logic [15:0] captureValue,
	input wire logic [15:0] compareValueA,
	output timer16_pkg::modeClass_t modeClass,
	output logic [15:0] topValue,
	output timer16_pkg::eventPoint_t updatePoint,
	output timer16_pkg::eventPoint_t overflowPoint
);
	wire isNonPwm = (waveModeSelect == `MODE_NORMAL) |
		(waveModeSelect == `MODE_CTC_CMP) |
		(waveModeSelect == `MODE_CTC_CAP);
	wire isReserved = waveModeSelect == `MODE_RSVD;
	wire lowFixed = ~waveModeSelect[3] & (|waveModeSelect[1:0]);
	wire isDual = (lowFixed & ~waveModeSelect[2]) |
		(waveModeSelect[3] & ~waveModeSelect[2]);
	wire isFreqCorrect = waveModeSelect[3:1] == 3'b100;
	wire usesCapture = waveModeSelect[3] & ~waveModeSelect[0];
	wire [15:0] fixedTop = (waveModeSelect[1:0] == 2'b01) ? `TOP_8BIT :
		(waveModeSelect[1:0] == 2'b10) ? `TOP_9BIT : `TOP_10BIT;

	assign modeClass = isReserved ? timer16_pkg::CLS_STOP :
		isNonPwm ? timer16_pkg::CLS_NONPWM :
		isDual ? timer16_pkg::CLS_DUAL : timer16_pkg::CLS_FAST;
	assign topValue = (waveModeSelect == `MODE_NORMAL) ? `TOP_MAX :
		lowFixed ? fixedTop :
		usesCapture ? captureValue : compareValueA;
	assign updatePoint = isNonPwm ? timer16_pkg::PT_IMMED :
		isFreqCorrect ? timer16_pkg::PT_BOTTOM : timer16_pkg::PT_TOP;
	assign overflowPoint = isNonPwm ? timer16_pkg::PT_MAX :
		isDual ? timer16_pkg::PT_BOTTOM : timer16_pkg::PT_TOP;
endmodule : wave_mode_decode
`default_nettype wire

// File: hdl/compare_channel.sv
// one compare output: applies the action code for the current mode class
`timescale 1ns/1ps
`default_nettype none
module compare_channel (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [1:0] action,
	input wire timer16_pkg::modeClass_t modeClass,
	input wire logic waveModeTopBit,
	input wire logic chanIsA,
	input wire logic match,
	input wire logic atTop,
	input wire logic countUp,
	input wire logic compareIsTop,
	output logic outLevel,
	output logic connected
);
	logic level_r;
	logic level_nxt;
	wire nonPwm = modeClass == timer16_pkg::CLS_NONPWM;
	// reserved B/C toggle is kept off the pin rather than guessed at
	wire toggleOk = (action == 2'b01) &
		(nonPwm | (waveModeTopBit & chanIsA));
	wire fastMatch = match & ~(compareIsTop & action[1]);

	assign connected = action[1] | toggleOk;
	assign outLevel = level_r;

	always_comb begin
		level_nxt = level_r;
		case (modeClass)
			timer16_pkg::CLS_NONPWM: begin
				if (match & toggleOk)
					level_nxt = ~level_r;
				else if (match & action[1])
					level_nxt = action[0];
			end
			timer16_pkg::CLS_FAST: begin
				if (atTop & action[1])
					level_nxt = ~action[0];
				else if (fastMatch & action[1])
					level_nxt = action[0];
				else if (match & toggleOk)
					level_nxt = ~level_r;
			end
			timer16_pkg::CLS_DUAL: begin
				if (match & action[1])
					level_nxt = countUp ? action[0] : ~action[0];
				else if (match & toggleOk)
					level_nxt = ~level_r;
			end
			default: level_nxt = level_r;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			level_r <= 1'b0;
		else
			level_r <= level_nxt;
	end
endmodule : compare_channel
`default_nettype wire

// File: tb/timer16_wave_mode_control_properties.sv
// port-level assertions for the wave mode timer, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"
module timer16_wave_mode_control_properties (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] portData,
	input wire logic [2:0] portDirOut,
	input wire logic [2:0] pinOut,
	input wire logic [2:0] pinOeN,
	input wire logic overflowFlag
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire logic hsAw = s_axi_awvalid && s_axi_awready;
	wire logic hsW = s_axi_wvalid && s_axi_wready;
	// shadow of channel A being off; any write in flight makes it unsure
	logic [2:0] quiet_r;
	logic [7:0] awLat_r;
	logic offLat_r;
	logic offA_r;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			quiet_r <= 3'h0;
			awLat_r <= 8'h0;
			offLat_r <= 1'h1;
			offA_r <= 1'h1;
		end else begin
			if (hsAw || hsW) quiet_r <= 3'h0;
			else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
			if (hsAw) awLat_r <= s_axi_awaddr;
			if (hsW) offLat_r <= s_axi_wstrb[0] ? s_axi_wdata[7:6] == 2'h0 : offA_r;
			if ($rose(s_axi_bvalid) && awLat_r[7:2] == 6'h0) offA_r <= offLat_r;
		end
	end
	property p_reset_state;
		!$past(rstn) |-> pinOeN == 3'h7 && pinOut == 3'h0 && !overflowFlag;
	endproperty
	property p_oe_dir;
		$past(rstn) |-> pinOeN == ~$past(portDirOut);
	endproperty
	property p_port_pass;
		quiet_r >= 3'h4 && offA_r |-> pinOut[0] == $past(portData[0]);
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_w_lat;
		hsAw && hsW |-> ##2 s_axi_bvalid;
	endproperty
	property p_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("outputs wrong after reset");
	a_oe_dir: assert property (p_oe_dir)
		else $error("pin enable not following direction");
	a_port_pass: assert property (p_port_pass)
		else $error("disconnected pin not showing port value");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped early");
	a_r_lat: assert property (p_r_lat)
		else $error("read answer late");
	a_w_lat: assert property (p_w_lat)
		else $error("write answer late");
	a_refuse: assert property (p_refuse)
		else $error("write accepted while response pending");
	c_write: cover property (hsAw && hsW);
	c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
	c_overflow: cover property ($rose(overflowFlag));
endmodule : timer16_wave_mode_control_properties
bind timer16_wave_mode_control timer16_wave_mode_control_properties u_props (
	.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .portData, .portDirOut,
	.pinOut, .pinOeN, .overflowFlag
);
`default_nettype wire

// File: tb/pin_load_model.sv
// external loads on the three compare pins, each with a pull-up
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
	input wire logic [2:0] pinOut,
	input wire logic [2:0] pinOeN,
	output logic [2:0] padLevel
);
	// a released pad floats to the pull-up, never to the last driven value
	assign padLevel = pinOeN | pinOut;
endmodule : pin_load_model
`default_nettype wire

// File: tb/timer16_wave_mode_control_tb.sv
// self-checking bench for the wave mode timer over its register bus
`timescale 1ns/1ps
`default_nettype none
`include "timer16_cfg.svh"
module timer16_wave_mode_control_tb;
	logic clk_sys = 1'h0;
	logic rstn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'h0;
	logic [2:0] portData = 3'h0;
	logic [2:0] portDirOut = 3'h0;
	logic [2:0] pinOut;
	logic [2:0] pinOeN;
	logic [2:0] padLevel;
	logic overflowFlag;
	logic [31:0] ones [3];
	logic lateReady = 1'h0;
	int fails = 0;
	int total_checks = 0;
	always #50 clk_sys = ~clk_sys;
	timer16_wave_mode_control dut (
		.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .portData, .portDirOut, .pinOut, .pinOeN, .overflowFlag
	);
	pin_load_model u_load (.pinOut, .pinOeN, .padLevel);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string m);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
		end
	endtask : chk
	// ready goes up with the request; lateReady stalls it to make the slave hold
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= ~lateReady;
		r = 2'h3;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
			if (s_axi_bvalid) s_axi_bready <= 1'h1;
		end
		chk({31'h0, n < 40}, 32'h1, "write hang");
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= ~lateReady;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
			if (s_axi_rvalid) s_axi_rready <= 1'h1;
		end
		chk({31'h0, n < 40}, 32'h1, "read hang");
	endtask : axr
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
		chk({30'h0, r}, {30'h0, `RESP_OKAY}, "write resp");
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(d, e, m);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : cyc
	task automatic duty(input int n);
		ones = '{default: 32'h0};
		repeat (n) begin
			@(negedge clk_sys);
			for (int i = 0; i < 3; i++) ones[i] += {31'h0, padLevel[i]};
		end
	endtask : duty
	task automatic cfg(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] c, input logic [7:0] ctl, input logic [7:0] ck);
		@(posedge clk_sys);
		rstn <= 1'h0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'h1;
		wr(`OFS_CMP_A, {16'h0, a});
		wr(`OFS_CMP_B, {16'h0, b});
		wr(`OFS_CMP_C, {16'h0, c});
		wr(`OFS_OUT_MODE_CTRL, {24'h0, ctl});
		wr(`OFS_CLK_MODE_CTRL, {24'h0, ck});
	endtask : cfg
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	initial begin
		#(100 * 20000);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic a0;
		logic [31:0] cnt;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'h1;
		rd(`OFS_OUT_MODE_CTRL, 32'h0, "ctrl reset");
		rd(`OFS_CLK_MODE_CTRL, 32'h0, "mode reset");
		chk({29'h0, padLevel}, 32'h7, "pads released");
		// two reads seven cycles apart with an ignored count write between
		axr(`OFS_COUNT, d, r);
		wr(`OFS_COUNT, 32'h0);
		axr(`OFS_COUNT, cnt, r);
		chk(cnt - d, 32'h7, "count runs, write ignored");
		wr(`OFS_CAPTURE, 32'hABCD);
		s_axi_wstrb <= 4'h2;
		wr(`OFS_CAPTURE, 32'h1200);
		s_axi_wstrb <= 4'hF;
		rd(`OFS_CAPTURE, 32'h12CD, "byte lanes");
		wr(`OFS_OUT_MODE_CTRL, 32'hFFFFFFFF);
		rd(`OFS_OUT_MODE_CTRL, 32'hFF, "ctrl fields");
		wr(`OFS_CLK_MODE_CTRL, 32'hFF);
		rd(`OFS_CLK_MODE_CTRL, 32'h18, "mode high bits");
		// mode 15 with TOP zero sees TOP every cycle, so the clear must lose
		wr(`OFS_STATUS, 32'h1);
		rd(`OFS_STATUS, 32'h1, "set beats clear");
		wr(`OFS_CLK_MODE_CTRL, 32'h0);
		wr(`OFS_STATUS, 32'h1);
		rd(`OFS_STATUS, 32'h0, "flag cleared");
		lateReady = 1'h1;
		axw(8'h20, 32'h1, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR}, "unmapped write");
		axr(8'h20, d, r);
		chk({r, d[29:0]}, {`RESP_SLVERR, 30'h0}, "unmapped read");
		lateReady = 1'h0;
		$display("test registers done");
		cfg(16'h40, 16'h4, 16'h4, 8'h6C, 8'h08);
		portDirOut <= 3'h7;
		cyc(200);
		chk({30'h0, padLevel[2:1]}, 32'h2, "clear and set");
		a0 = padLevel[0];
		cyc(65);
		chk({31'h0, padLevel[0]}, {31'h0, ~a0}, "toggle period");
		rd(`OFS_STATUS, 32'h0, "no flag at TOP");
		@(posedge clk_sys);
		portDirOut <= 3'h0;
		cyc(2);
		chk({29'h0, padLevel}, 32'h7, "direction gates");
		wr(`OFS_OUT_MODE_CTRL, 32'h2C);
		portDirOut <= 3'h7;
		portData <= 3'h1;
		cyc(3);
		chk({31'h0, padLevel[0]}, 32'h1, "port high");
		@(posedge clk_sys);
		portData <= 3'h0;
		cyc(3);
		chk({31'h0, padLevel[0]}, 32'h0, "port low");
		$display("test clear on match done");
		cfg(16'h80, 16'h80, 16'hFF, 8'hB9, 8'h08);
		cyc(600);
		duty(256);
		chk(ones[0], 32'h81, "fast clear");
		chk(ones[1], 32'h7F, "fast set");
		chk(ones[2], 32'h100, "compare at top");
		rd(`OFS_STATUS, 32'h1, "overflow at top");
		chk({31'h0, overflowFlag}, 32'h1, "flag pin");
		$display("test fast done");
		cfg(16'h80, 16'h80, 16'h0, 8'hB5, 8'h00);
		portData <= 3'h4;
		cyc(1200);
		duty(510);
		chk(ones[0], 32'h100, "dual clear");
		chk(ones[1], 32'hFE, "dual set");
		chk(ones[2], 32'h1FE, "code one off");
		$display("test dual slope done");
		cfg(16'h40, 16'h0, 16'h0, 8'h53, 8'h10);
		portData <= 3'h2;
		cyc(600);
		duty(256);
		chk(ones[0], 32'h80, "toggle A");
		chk(ones[1], 32'h100, "reserved B");
		$display("test top bit done");
		wr(`OFS_OUT_MODE_CTRL, 32'h51);
		wr(`OFS_CLK_MODE_CTRL, 32'h18);
		axr(`OFS_COUNT, d, r);
		axr(`OFS_COUNT, cnt, r);
		chk(cnt, d, "reserved mode holds");
		$display("test reserved mode done");
		// TOP is loaded before the mode switch so the count stays below it
		cfg(16'h80, 16'h0, 16'h0, 8'h40, 8'h00);
		wr(`OFS_CAPTURE, 32'hFF);
		wr(`OFS_CLK_MODE_CTRL, 32'h18);
		cyc(300);
		duty(512);
		chk(ones[0], 32'h100, "capture top");
		rd(`OFS_STATUS, 32'h0, "flag at MAX only");
		$display("test capture clear done");
		cfg(16'h0, 16'h40, 16'h0, 8'h20, 8'h00);
		wr(`OFS_CAPTURE, 32'h80);
		wr(`OFS_CLK_MODE_CTRL, 32'h10);
		cyc(300);
		duty(256);
		chk(ones[1], 32'h80, "freq correct clear");
		rd(`OFS_STATUS, 32'h1, "flag at bottom");
		chk({31'h0, overflowFlag}, 32'h1, "flag pin bottom");
		$display("test freq correct done");
		summarize();
	end
endmodule : timer16_wave_mode_control_tb
`default_nettype wire
